// [hdl/ocu_pkg.sv]
// output compare unit: register map, field layout, mode codes, bus codes
// assumes a 32-bit ahb-lite slave port decoding the low address byte
package ocu_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMP_LOW  = 8'h00;
  localparam logic [7:0] OFS_CMP_HIGH = 8'h04;
  localparam logic [7:0] OFS_CTL      = 8'h08;
  localparam logic [7:0] OFS_FLAGS    = 8'h0C;
  localparam logic [7:0] OFS_ENABLES  = 8'h10;
  localparam logic [7:0] OFS_PRIORITY = 8'h14;
  localparam logic [7:0] OFS_TASSIGN  = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  // field positions and widths
  localparam int unsigned CTL_W       = 6;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_W      = 4;
  localparam int unsigned DUTY_LSB    = 4;
  localparam int unsigned CH_BIT      = 1;
  localparam int unsigned TSEL_LSB    = 0;
  localparam int unsigned TSEL_W      = 2;
  localparam int unsigned STAT_LATCH  = 0;
  localparam int unsigned STAT_PIN    = 1;

  // reset values
  localparam logic [7:0]        RST_BYTE = 8'h00;
  localparam logic [CTL_W-1:0]  RST_CTL  = 6'h00;
  localparam logic [TSEL_W-1:0] RST_TSEL = 2'h0;

  // mode select codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_HIGH    = 4'h8;
  localparam logic [3:0] MODE_LOW     = 4'h9;
  localparam logic [3:0] MODE_SWINT   = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;

  // timer select codes
  localparam logic [1:0] TSEL_A     = 2'h0;
  localparam logic [1:0] TSEL_B     = 2'h1;
  localparam logic [1:0] TSEL_B_ALT = 2'h2;

  // ahb-lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  // mode is one of the compare codes
  function automatic logic is_compare(input logic [3:0] mode);
    return (mode == MODE_TOGGLE) || (mode == MODE_HIGH) || (mode == MODE_LOW) ||
           (mode == MODE_SWINT) || (mode == MODE_SPECIAL);
  endfunction

  // mode lets the compare latch drive the pin
  function automatic logic drives_pin(input logic [3:0] mode);
    return (mode == MODE_TOGGLE) || (mode == MODE_HIGH) || (mode == MODE_LOW);
  endfunction

endpackage

// [hdl/ocu_ahb_slave.sv]
// ahb-lite slave front end: one wait state per word transfer
// assumes single transfers of whole words, hready_i is this slave's own hreadyout
`timescale 1ns/1ps
module ocu_ahb_slave #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic              hready_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic [31:0]       rdata_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic                   wr_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [31:0]       wdata_o
);

  logic              accept;
  logic              pend_r;
  logic              write_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0]       hrdata_r;
  logic              hready_r;
  logic              hresp_r;

  // nonseq or seq word transfer taken while bus ready
  assign accept = hsel_i && htrans_i[1] && hready_i && (hsize_i == ocu_pkg::HSIZE_WORD);

  // address phase capture and one-cycle wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r   <= 1'b0;
      hready_r <= 1'b1;
      write_r  <= 1'b0;
      addr_r   <= '0;
    end else begin
      pend_r   <= accept;
      hready_r <= !accept;
      if (accept) begin
        write_r <= hwrite_i;
        addr_r  <= haddr_i[ADDR_W-1:0];
      end
    end
  end

  // read data sampled after any write of the previous transfer landed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (pend_r && !write_r) begin
      hrdata_r <= rdata_i;
    end
  end

  // response is always okay
  always_ff @(posedge clk_i) begin
    hresp_r <= ocu_pkg::HRESP_OKAY;
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = hready_r;
  assign hresp_o     = hresp_r;
  assign wr_o        = pend_r && write_r;
  assign addr_o      = addr_r;
  assign wdata_o     = hwdata_i;

  // exactly one wait state after each accepted transfer
  property p_one_wait;
    @(posedge clk_i) disable iff (rst_i) accept |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait state not exactly one cycle");

endmodule

// [hdl/ocu_match.sv]
// compare engine: selects the assigned timer count and flags a new match
// assumes both timer counts come from logic on clk_i
`timescale 1ns/1ps
module ocu_match #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [CNT_W-1:0] timer_a_count_i,
  input  wire logic [CNT_W-1:0] timer_b_count_i,
  input  wire logic [1:0]       timer_select_i,
  input  wire logic [CNT_W-1:0] compare_value_i,
  input  wire logic             compare_en_i,
  output logic                  match_evt_o
);

  logic [CNT_W-1:0] count_sel;
  logic             sel_valid;
  logic             hit;
  logic             hit_r;

  // time base chosen by timer select, reserved code selects none
  always_comb begin
    count_sel = timer_a_count_i;
    sel_valid = 1'b1;
    unique case (timer_select_i)
      ocu_pkg::TSEL_A:     count_sel = timer_a_count_i;
      ocu_pkg::TSEL_B:     count_sel = timer_b_count_i;
      ocu_pkg::TSEL_B_ALT: count_sel = timer_b_count_i;
      default:             sel_valid = 1'b0;
    endcase
  end

  // full-width equality every cycle
  assign hit = compare_en_i && sel_valid && (count_sel == compare_value_i);

  // only the first cycle of a match is an event, so a stalled timer acts once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit;
    end
  end

  assign match_evt_o = hit && !hit_r;

endmodule

// [hdl/ocu_top.sv]
// output compare unit top: registers, compare latch, pin mux, special event trigger
// assumes an ahb-lite master on clk_i and timers and port latch on the same clock
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module ocu_top #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic             hready_i,
  input  wire logic [31:0]      hwdata_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic [CNT_W-1:0] timer_a_count_i,
  input  wire logic [CNT_W-1:0] timer_b_count_i,
  input  wire logic             port_latch_i,
  output logic                  pin_out_o,
  output logic                  compare_latch_o,
  output logic                  special_event_o,
  output logic                  timer_a_clear_o,
  output logic                  timer_b_clear_o,
  output logic                  match_irq_o,
  output logic                  match_irq_priority_o
);

  localparam int unsigned ADDR_W = 8;

  // bus side
  logic                          bus_wr;
  logic [ADDR_W-1:0]             bus_addr;
  logic [31:0]                   bus_wdata;
  logic [31:0]                   rdata;

  // software registers
  logic [7:0]                    cmp_low_r;
  logic [7:0]                    cmp_high_r;
  logic [ocu_pkg::CTL_W-1:0]     ctl_r;
  logic                          flag_r;
  logic                          ie_r;
  logic                          ip_r;
  logic [ocu_pkg::TSEL_W-1:0]    tsel_r;

  // channel state
  logic [3:0]                    mode;
  logic [CNT_W-1:0]              compare_value;
  logic                          match_evt;
  logic                          latch_r;
  logic                          latch_nxt;
  logic                          pin_out_r;
  logic                          sev_r;
  logic                          clr_a_r;
  logic                          clr_b_r;
  logic                          irq_r;

  // register write strobes
  logic                          wr_low;
  logic                          wr_high;
  logic                          wr_ctl;
  logic                          wr_flags;
  logic                          wr_ie;
  logic                          wr_ip;
  logic                          wr_tsel;
  logic                          ctl_zero_wr;

  // bus slave front end
  ocu_ahb_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .rdata_i     (rdata),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .wr_o        (bus_wr),
    .addr_o      (bus_addr),
    .wdata_o     (bus_wdata)
  );

  // address decode of data-phase writes
  assign wr_low      = bus_wr && (bus_addr == ocu_pkg::OFS_CMP_LOW);
  assign wr_high     = bus_wr && (bus_addr == ocu_pkg::OFS_CMP_HIGH);
  assign wr_ctl      = bus_wr && (bus_addr == ocu_pkg::OFS_CTL);
  assign wr_flags    = bus_wr && (bus_addr == ocu_pkg::OFS_FLAGS);
  assign wr_ie       = bus_wr && (bus_addr == ocu_pkg::OFS_ENABLES);
  assign wr_ip       = bus_wr && (bus_addr == ocu_pkg::OFS_PRIORITY);
  assign wr_tsel     = bus_wr && (bus_addr == ocu_pkg::OFS_TASSIGN);
  assign ctl_zero_wr = wr_ctl && (bus_wdata[7:0] == ocu_pkg::RST_BYTE);

  // compare value byte registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_low_r  <= ocu_pkg::RST_BYTE;
      cmp_high_r <= ocu_pkg::RST_BYTE;
    end else begin
      if (wr_low) begin
        cmp_low_r <= bus_wdata[7:0];
      end
      if (wr_high) begin
        cmp_high_r <= bus_wdata[7:0];
      end
    end
  end

  // control, enable, priority and timer assignment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r  <= ocu_pkg::RST_CTL;
      ie_r   <= 1'b0;
      ip_r   <= 1'b0;
      tsel_r <= ocu_pkg::RST_TSEL;
    end else begin
      if (wr_ctl) begin
        ctl_r <= bus_wdata[ocu_pkg::CTL_W-1:0];
      end
      if (wr_ie) begin
        ie_r <= bus_wdata[ocu_pkg::CH_BIT];
      end
      if (wr_ip) begin
        ip_r <= bus_wdata[ocu_pkg::CH_BIT];
      end
      if (wr_tsel) begin
        tsel_r <= bus_wdata[ocu_pkg::TSEL_LSB +: ocu_pkg::TSEL_W];
      end
    end
  end

  assign mode          = ctl_r[ocu_pkg::MODE_LSB +: ocu_pkg::MODE_W];
  assign compare_value = {cmp_high_r, cmp_low_r};

  // compare engine on the assigned time base
  ocu_match #(
    .CNT_W (CNT_W)
  ) u_match (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .timer_a_count_i (timer_a_count_i),
    .timer_b_count_i (timer_b_count_i),
    .timer_select_i  (tsel_r),
    .compare_value_i (compare_value),
    .compare_en_i    (ocu_pkg::is_compare(mode)),
    .match_evt_o     (match_evt)
  );

  // next compare latch: match action, then zero-control clear
  always_comb begin
    latch_nxt = latch_r;
    if (match_evt) begin
      unique case (mode)
        ocu_pkg::MODE_TOGGLE: latch_nxt = !latch_r;
        ocu_pkg::MODE_HIGH:   latch_nxt = 1'b1;
        ocu_pkg::MODE_LOW:    latch_nxt = 1'b0;
        default:              latch_nxt = latch_r;
      endcase
    end
    if (ctl_zero_wr) begin
      latch_nxt = 1'b0;
    end
  end

  // compare latch and pin mux; port latch itself is never touched here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_r   <= 1'b0;
      pin_out_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      if (ocu_pkg::drives_pin(mode)) begin
        pin_out_r <= latch_nxt;
      end else begin
        pin_out_r <= port_latch_i;
      end
    end
  end

  // match flag: hardware set wins over a software clear, cleared only by a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else begin
      if (wr_flags) begin
        flag_r <= bus_wdata[ocu_pkg::CH_BIT];
      end
      if (match_evt) begin
        flag_r <= 1'b1;
      end
    end
  end

  // interrupt request level from flag and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r && ie_r;
    end
  end

  // special event pulse and clear of the assigned timer only; no conversion start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sev_r   <= 1'b0;
      clr_a_r <= 1'b0;
      clr_b_r <= 1'b0;
    end else begin
      sev_r   <= match_evt && (mode == ocu_pkg::MODE_SPECIAL);
      clr_a_r <= match_evt && (mode == ocu_pkg::MODE_SPECIAL) &&
                 (tsel_r == ocu_pkg::TSEL_A);
      clr_b_r <= match_evt && (mode == ocu_pkg::MODE_SPECIAL) &&
                 ((tsel_r == ocu_pkg::TSEL_B) || (tsel_r == ocu_pkg::TSEL_B_ALT));
    end
  end

  // read mux; unmapped offsets and unused bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (bus_addr)
      ocu_pkg::OFS_CMP_LOW:  rdata[7:0] = cmp_low_r;
      ocu_pkg::OFS_CMP_HIGH: rdata[7:0] = cmp_high_r;
      ocu_pkg::OFS_CTL:      rdata[ocu_pkg::CTL_W-1:0] = ctl_r;
      ocu_pkg::OFS_FLAGS:    rdata[ocu_pkg::CH_BIT] = flag_r;
      ocu_pkg::OFS_ENABLES:  rdata[ocu_pkg::CH_BIT] = ie_r;
      ocu_pkg::OFS_PRIORITY: rdata[ocu_pkg::CH_BIT] = ip_r;
      ocu_pkg::OFS_TASSIGN:  rdata[ocu_pkg::TSEL_LSB +: ocu_pkg::TSEL_W] = tsel_r;
      ocu_pkg::OFS_STATUS: begin
        rdata[ocu_pkg::STAT_LATCH] = latch_r;
        rdata[ocu_pkg::STAT_PIN]   = pin_out_r;
      end
      default:               rdata = 32'h0000_0000;
    endcase
  end

  // outputs straight from flops
  assign pin_out_o            = pin_out_r;
  assign compare_latch_o      = latch_r;
  assign special_event_o      = sev_r;
  assign timer_a_clear_o      = clr_a_r;
  assign timer_b_clear_o      = clr_b_r;
  assign match_irq_o          = irq_r;
  assign match_irq_priority_o = ip_r;

  // checks on the channel behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a match only when the selected count equals the whole value
  property p_full_compare;
    match_evt |-> ((tsel_r == ocu_pkg::TSEL_A) ? (timer_a_count_i == compare_value)
                                               : (timer_b_count_i == compare_value));
  endproperty
  a_full_compare: assert property (p_full_compare) else $error("match without full equality");

  property p_drive_high;
    match_evt && (mode == ocu_pkg::MODE_HIGH) && !ctl_zero_wr |=> latch_r && pin_out_r;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("high mode did not drive pin high");

  property p_toggle;
    match_evt && (mode == ocu_pkg::MODE_TOGGLE) && !ctl_zero_wr |=> latch_r != $past(latch_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle mode did not toggle");

  property p_flag_with_pin;
    match_evt |=> flag_r && (!ocu_pkg::drives_pin($past(mode)) || (pin_out_r == latch_r));
  endproperty
  a_flag_with_pin: assert property (p_flag_with_pin) else $error("flag and pin action not together");

  property p_zero_clears;
    ctl_zero_wr |=> !latch_r ##1 (pin_out_r == $past(port_latch_i));
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("zero control write left latch high");

  property p_swint_pin;
    match_evt && (mode == ocu_pkg::MODE_SWINT) |=> (pin_out_r == $past(port_latch_i)) && flag_r;
  endproperty
  a_swint_pin: assert property (p_swint_pin) else $error("software interrupt mode moved the pin");

  property p_sev_cause;
    sev_r |-> $past(match_evt) && ($past(mode) == ocu_pkg::MODE_SPECIAL) ##1 !sev_r;
  endproperty
  a_sev_cause: assert property (p_sev_cause) else $error("trigger without special event match");

  property p_sev_clears_timer;
    sev_r |-> (clr_a_r != clr_b_r) && (clr_a_r == ($past(tsel_r) == ocu_pkg::TSEL_A));
  endproperty
  a_sev_clears_timer: assert property (p_sev_clears_timer) else $error("trigger cleared wrong timer");

  property p_value_pair;
    wr_high |=> compare_value[15:8] == $past(bus_wdata[7:0]);
  endproperty
  a_value_pair: assert property (p_value_pair) else $error("high byte not in compare value");

  property p_drive_low;
    match_evt && (mode == ocu_pkg::MODE_LOW) && !ctl_zero_wr |=> !latch_r && !pin_out_r;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("low mode did not drive pin low");

  // pin reflects the port latch whenever the mode does not drive it
  property p_pin_on_port;
    !ocu_pkg::drives_pin(mode) |=> pin_out_r == $past(port_latch_i);
  endproperty
  a_pin_on_port: assert property (p_pin_on_port) else $error("pin left the port latch");

  // reserved timer select never yields a match
  property p_reserved_sel;
    (tsel_r != ocu_pkg::TSEL_A) && (tsel_r != ocu_pkg::TSEL_B) &&
    (tsel_r != ocu_pkg::TSEL_B_ALT) |-> !match_evt;
  endproperty
  a_reserved_sel: assert property (p_reserved_sel) else $error("match on reserved timer select");

  // flag only leaves the set state through a bus write
  property p_flag_kept;
    flag_r && !wr_flags |=> flag_r;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag cleared without a write");

  c_toggle:  cover property (match_evt && (mode == ocu_pkg::MODE_TOGGLE));
  c_special: cover property (sev_r && clr_b_r);
  c_swint:   cover property (match_evt && (mode == ocu_pkg::MODE_SWINT) ##2 irq_r);
  c_clear:   cover property (latch_r ##1 ctl_zero_wr);

endmodule

// [tb/ocu_timer_model.sv]
// partner model: two synchronous timers seen by the compare unit
// assumes clear pulses and load requests come on clk_i
`timescale 1ns/1ps
module ocu_timer_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_a_i,
  input  wire logic [15:0] load_b_i,
  input  wire logic        clear_a_i,
  input  wire logic        clear_b_i,
  output logic      [15:0] count_a_o,
  output logic      [15:0] count_b_o
);
  // timer a, counts on the system clock only
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_a_i) begin
      count_a_o <= 16'h0000;
    end else if (load_i) begin
      count_a_o <= load_a_i;
    end else if (run_i) begin
      count_a_o <= count_a_o + 16'h0001;
    end
  end

  // timer b, same synchronous mode
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_b_i) begin
      count_b_o <= 16'h0000;
    end else if (load_i) begin
      count_b_o <= load_b_i;
    end else if (run_i) begin
      count_b_o <= count_b_o + 16'h0001;
    end
  end
endmodule

// [tb/ocu_top_test.sv]
// testbench: ahb-lite register access and compare actions of ocu_top
// assumes ocu_timer_model as the timers, port latch driven here
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ocu_top_test;
  logic        clk_i, rst_i, hsel, hwrite, port_r, run, load;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        hready, hresp, pin, latch, sev, clr_a, clr_b, irq, prio;
  logic [15:0] cnt_a, cnt_b, ld_a, ld_b;
  int          n_mismatch, n_checks;

  // design and timers
  ocu_top ocu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(ocu_pkg::HSIZE_WORD), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .timer_a_count_i(cnt_a), .timer_b_count_i(cnt_b), .port_latch_i(port_r), .pin_out_o(pin), // pin kept as output
    .compare_latch_o(latch), .special_event_o(sev), .timer_a_clear_o(clr_a),
    .timer_b_clear_o(clr_b), .match_irq_o(irq), .match_irq_priority_o(prio));
  ocu_timer_model ocu_timer_model_inst (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .load_i(load), .load_a_i(ld_a), .load_b_i(ld_b), .clear_a_i(clr_a), .clear_b_i(clr_b),
    .count_a_o(cnt_a), .count_b_o(cnt_b));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic stall();
    n_mismatch++;
    $display("[FAIL] %0t wait timeout", $time);
    complete_run();
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_i);
      if (hready === 1'b1) break;
    end
    if (i == 8) stall();
  endtask

  // one word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(hresp, ocu_pkg::HRESP_OKAY)
  endtask

  // stop timers, preload, program channel, restart
  task automatic arm(input logic [3:0] m, input logic [1:0] s, input logic [15:0] v);
    run  <= 1'b0;
    load <= 1'b1;
    ld_a <= v - ((s == ocu_pkg::TSEL_A) ? 16'h0014 : 16'h0002);
    ld_b <= v - ((s == ocu_pkg::TSEL_A) ? 16'h0002 : 16'h0014);
    @(posedge clk_i);
    load <= 1'b0;
    wr(ocu_pkg::OFS_TASSIGN, {6'h00, s});
    wr(ocu_pkg::OFS_CMP_LOW, v[7:0]);
    wr(ocu_pkg::OFS_CMP_HIGH, v[15:8]);
    wr(ocu_pkg::OFS_CTL, {4'h0, m});
    run <= 1'b1;
  endtask

  // wait until the selected count first equals v
  task automatic hit(input logic [15:0] v, input logic b);
    int i;
    for (i = 0; i < 100; i++) begin
      step();
      if ((b ? cnt_b : cnt_a) === v) break;
    end
    if (i == 100) stall();
  endtask

  task automatic t_regs();
    for (int k = 0; k < 9; k++) rdchk(8'(k * 4), 32'h0000_0000);
    wr(ocu_pkg::OFS_CMP_LOW, 8'hA5);
    wr(ocu_pkg::OFS_CMP_HIGH, 8'h5A);
    wr(ocu_pkg::OFS_CTL, 8'hF7);
    wr(ocu_pkg::OFS_STATUS, 8'hFF);
    wr(8'h20, 8'hFF);
    wr(ocu_pkg::OFS_PRIORITY, 8'h02);
    rdchk(ocu_pkg::OFS_CMP_LOW, 32'h0000_00A5);
    rdchk(ocu_pkg::OFS_CMP_HIGH, 32'h0000_005A);
    rdchk(ocu_pkg::OFS_CTL, 32'h0000_0037);
    rdchk(ocu_pkg::OFS_STATUS, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    rdchk(ocu_pkg::OFS_PRIORITY, 32'h0000_0002);
    `CHK(prio, 1'b1)
    $display("%0t regs done", $time);
  endtask

  task automatic t_pin();
    logic [3:0]  m[3] = '{ocu_pkg::MODE_HIGH, ocu_pkg::MODE_LOW, ocu_pkg::MODE_TOGGLE};
    logic [1:0]  s[3] = '{ocu_pkg::TSEL_A, ocu_pkg::TSEL_B, ocu_pkg::TSEL_B_ALT};
    logic [15:0] v[3] = '{16'h1234, 16'h3456, 16'h5678};
    logic        e[3] = '{1'b1, 1'b0, 1'b1};
    wr(ocu_pkg::OFS_ENABLES, 8'h02);
    for (int k = 0; k < 3; k++) begin
      arm(m[k], s[k], v[k]);
      hit(v[k], s[k] != ocu_pkg::TSEL_A);
      `CHK(latch, ~e[k])
      step();
      `CHK(latch, e[k])
      `CHK(pin, e[k])
      `CHK(sev, 1'b0)
      step();
      `CHK(irq, 1'b1)
      rdchk(ocu_pkg::OFS_FLAGS, 32'h0000_0002);
      wr(ocu_pkg::OFS_FLAGS, 8'h00);
      rdchk(ocu_pkg::OFS_FLAGS, 32'h0000_0000);
    end
    $display("%0t pin done", $time);
  endtask

  task automatic t_swint();
    port_r <= 1'b0;
    arm(ocu_pkg::MODE_SWINT, ocu_pkg::TSEL_A, 16'h7878);
    hit(16'h7878, 1'b0);
    step();
    `CHK(latch, 1'b1)
    `CHK(pin, 1'b0)
    rdchk(ocu_pkg::OFS_FLAGS, 32'h0000_0002);
    wr(ocu_pkg::OFS_FLAGS, 8'h00);
    $display("%0t swint done", $time);
  endtask

  task automatic t_special();
    arm(ocu_pkg::MODE_SPECIAL, ocu_pkg::TSEL_A, 16'h0030);
    hit(16'h0030, 1'b0);
    step();
    `CHK({sev, clr_a, clr_b}, 3'b110)
    step();
    `CHK({sev, cnt_a}, 17'h0_0000)
    hit(16'h0030, 1'b0);
    step();
    `CHK(sev, 1'b1)
    arm(ocu_pkg::MODE_SPECIAL, ocu_pkg::TSEL_B, 16'h0040);
    hit(16'h0040, 1'b1);
    step();
    `CHK({sev, clr_a, clr_b}, 3'b101)
    wr(ocu_pkg::OFS_FLAGS, 8'h00);
    arm(ocu_pkg::MODE_SPECIAL, 2'h3, 16'h0050);
    repeat (24) step();
    `CHK(cnt_b > 16'h0050, 1'b1)
    rdchk(ocu_pkg::OFS_FLAGS, 32'h0000_0000);
    $display("%0t special done", $time);
  endtask

  task automatic t_off();
    port_r <= 1'b1;
    `CHK(latch, 1'b1)
    wr(ocu_pkg::OFS_CTL, 8'h00);
    step();
    `CHK({latch, pin}, 2'b01)
    rdchk(ocu_pkg::OFS_STATUS, 32'h0000_0002);
    $display("%0t off done", $time);
  endtask

  // reset, then the scenarios
  initial begin
    {rst_i, hsel, hwrite, port_r, run, load} = 6'b100000;
    {htrans, haddr, hwdata, ld_a, ld_b} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pin();
    t_swint();
    t_special();
    t_off();
    complete_run();
  end
endmodule
